//--- src/rsc_consts.svh
// reset source controller: offsets, field positions, reset values, timing
// assumes inclusion by bare name from the controller module only
`ifndef RSC_CONSTS_SVH
`define RSC_CONSTS_SVH
// =====================================================
// register offsets
`define RSC_OFS_FLAGS 8'h00
`define RSC_OFS_SWRST 8'h01
// =====================================================
// field positions
`define RSC_BIT_GO 0
`define RSC_BIT_DBG 5
`define RSC_BIT_SW 4
`define RSC_BIT_WDT 3
`define RSC_BIT_PIN 2
`define RSC_BIT_BOD 1
`define RSC_BIT_POR 0
`define RSC_FLAGS_W 6
// =====================================================
// reset values
`define RSC_FLAGS_POR_ONLY 6'h01
`define RSC_SWRST_RST 8'h00
`define RSC_SYNC_INIT 5'h04
// =====================================================
// timing
`define RSC_CLK_MHZ 40
`define RSC_SUT_STEP_US 1000
`define RSC_SUT_STEP_CYC (`RSC_SUT_STEP_US * `RSC_CLK_MHZ)
`define RSC_CNT_W 20
`define RSC_SUT_MAX_CODE 7
`endif

//--- src/rsc_pkg.sv
// reset source controller: shared types
// assumes rsc_consts.svh on the include path
package rsc_pkg;
  // =====================================================
  // sequencer states
  typedef enum logic [2:0] {
    ST_HOLD,
    ST_FUSE,
    ST_SUT,
    ST_SCAN,
    ST_RUN
  } rsc_state_e;
  // =====================================================
  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rsc_bus_s;
  // =====================================================
  // fuse settings, static while running
  typedef struct packed {
    logic pin_en;
    logic bod_en;
    logic scan_en;
    logic [2:0] startup_time_setting;
  } rsc_fuse_s;
  // =====================================================
  // raw asynchronous request levels
  typedef struct packed {
    logic dbg;
    logic wdt;
    logic pin_n;
    logic brownout_detector;
    logic por;
  } rsc_src_s;
endpackage : rsc_pkg

//--- src/rsc_sync.sv
// reset source controller: two-flop level synchroniser
// assumes inputs asynchronous to i_mclk
`timescale 1ns/1ps
module rsc_sync #(
  parameter int W = 5,
  parameter logic [W-1:0] P_INIT = '0
) (
  // clock and control
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // data
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta;

  if (W < 1) begin : g_bad_w
    $error("rsc_sync width must be at least one");
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      meta <= P_INIT;
      o_q <= P_INIT;
    end else if (i_ce) begin
      meta <= i_d;
      o_q <= meta;
    end
  end
endmodule : rsc_sync

//--- src/rsc_reset_source_controller.sv
// reset source controller: request gathering, init sequencing, cause flags
// assumes a fuse loader and memory scan unit with level request/done handshakes
// Notes on behaviour
// - controller always on; each source needing enable is gated by its enable
// - every reset reloads fuse-loaded registers before running again
// - power-on always enabled, holds reset until whole init sequence ends
// - enabled reset pin low requests reset until pin high again
// - watchdog timeout request is accepted as system reset
// - writing one to trigger bit starts reset at once, held until done
// - trigger bit always reads zero
// - all resets reload fuses; only supply resets reset debug port logic
// - init after release; start-up delay added only for supply resets
// - enabled memory scan runs as part of reset init
// - works in active and every sleep mode
// - protected write without unlock leaves register unchanged
// - trigger register protected by io key; flags unprotected
// - flags bits 5..0: debug, software, watchdog, pin, brown-out, power-on
// - writing one clears a flag, zero leaves it
// - power-on clears all flags but sets power-on flag
// - after power-on no other flag sets until full boot completes
`timescale 1ns/1ps
`include "rsc_consts.svh"
module rsc_reset_source_controller #(
  parameter int P_SUT_STEP_CYC = `RSC_SUT_STEP_CYC
) (
  // clock, power-on reset, clock enable
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // register port
  input wire rsc_pkg::rsc_bus_s i_bus,
  output logic [7:0] o_rdata,
  // change protection window open for io key
  input wire logic i_ccp_unlock,
  // fuses and software enables
  input wire rsc_pkg::rsc_fuse_s i_fuse,
  input wire logic i_wdt_en,
  // raw reset requests
  input wire rsc_pkg::rsc_src_s i_src,
  // fuse reload handshake
  output logic o_fuse_load,
  input wire logic i_fuse_done,
  // memory scan handshake
  output logic o_scan_run,
  input wire logic i_scan_done,
  // reset outputs
  output logic o_sys_rst_n,
  output logic o_dbg_rst_n,
  output logic [`RSC_FLAGS_W-1:0] o_flags
);
  import rsc_pkg::*;

  // =====================================================
  // parameter check
  if (P_SUT_STEP_CYC < 1 ||
      longint'(P_SUT_STEP_CYC) * `RSC_SUT_MAX_CODE >= (longint'(1) << `RSC_CNT_W)) begin : g_bad_sut
    $error("start-up step does not fit the delay counter");
  end

  // =====================================================
  // declarations
  rsc_src_s src_q;
  rsc_state_e state;
  logic [`RSC_FLAGS_W-1:0] flags;
  logic [`RSC_FLAGS_W-1:0] cause;
  logic [`RSC_FLAGS_W-1:0] next_flags;
  logic [`RSC_CNT_W-1:0] sut_cnt;
  logic sw_go;
  logic pwr_req;
  logic req_any;
  logic power_seq;
  logic boot_lock;
  logic wr_flags;
  logic wr_swrst;
  logic sut_needed;

  // =====================================================
  // input synchronisation
  rsc_sync #(
    .W(5),
    .P_INIT(`RSC_SYNC_INIT)
  ) u_sync (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_d(i_src),
    .o_q(src_q)
  );

  // =====================================================
  // address decode
  assign wr_flags = i_bus.wr && (i_bus.addr == `RSC_OFS_FLAGS);
  assign wr_swrst = i_bus.wr && (i_bus.addr == `RSC_OFS_SWRST);

  // trigger only with unlock window open
  assign sw_go = wr_swrst && i_ccp_unlock && i_bus.wdata[`RSC_BIT_GO];

  // =====================================================
  // request gathering
  always_comb begin
    cause = '0;
    cause[`RSC_BIT_POR] = src_q.por;
    cause[`RSC_BIT_BOD] = src_q.brownout_detector && i_fuse.bod_en;
    cause[`RSC_BIT_PIN] = !src_q.pin_n && i_fuse.pin_en;
    cause[`RSC_BIT_WDT] = src_q.wdt && i_wdt_en;
    cause[`RSC_BIT_SW] = sw_go;
    cause[`RSC_BIT_DBG] = src_q.dbg;
  end

  assign pwr_req = cause[`RSC_BIT_POR] || cause[`RSC_BIT_BOD];
  assign req_any = |cause;
  assign sut_needed = power_seq && (i_fuse.startup_time_setting != 3'h0);

  // =====================================================
  // init sequencer
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      state <= ST_HOLD;
    end else if (i_ce) begin
      if (req_any) begin
        state <= ST_HOLD;
      end else begin
        case (state)
          ST_HOLD: begin
            state <= ST_FUSE;
          end
          ST_FUSE: begin
            if (i_fuse_done) begin
              if (sut_needed) begin
                state <= ST_SUT;
              end else if (i_fuse.scan_en) begin
                state <= ST_SCAN;
              end else begin
                state <= ST_RUN;
              end
            end
          end
          ST_SUT: begin
            if (sut_cnt == '0) begin
              state <= i_fuse.scan_en ? ST_SCAN : ST_RUN;
            end
          end
          ST_SCAN: begin
            if (i_scan_done) begin
              state <= ST_RUN;
            end
          end
          ST_RUN: begin
            state <= ST_RUN;
          end
          default: begin
            state <= ST_HOLD;
          end
        endcase
      end
    end
  end

  // =====================================================
  // start-up delay counter
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      sut_cnt <= '0;
    end else if (i_ce) begin
      if (state == ST_FUSE) begin
        sut_cnt <= `RSC_CNT_W'(i_fuse.startup_time_setting * P_SUT_STEP_CYC - 1);
      end else if (state == ST_SUT && sut_cnt != '0) begin
        sut_cnt <= sut_cnt - `RSC_CNT_W'(1);
      end
    end
  end

  // =====================================================
  // supply-reset tracking
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      power_seq <= 1'b1;
    end else if (i_ce) begin
      if (state == ST_RUN) begin
        power_seq <= pwr_req;
      end else begin
        power_seq <= power_seq || pwr_req;
      end
    end
  end

  // =====================================================
  // boot lock after power-on
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      boot_lock <= 1'b1;
    end else if (i_ce) begin
      if (cause[`RSC_BIT_POR]) begin
        boot_lock <= 1'b1;
      end else if (state == ST_RUN) begin
        boot_lock <= 1'b0;
      end
    end
  end

  // =====================================================
  // cause flags
  always_comb begin
    next_flags = flags;
    if (wr_flags) begin
      next_flags = next_flags & ~i_bus.wdata[`RSC_FLAGS_W-1:0];
    end
    if (!boot_lock) begin
      next_flags = next_flags | cause;
    end
    if (cause[`RSC_BIT_POR]) begin
      next_flags = `RSC_FLAGS_POR_ONLY;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      flags <= `RSC_FLAGS_POR_ONLY;
    end else if (i_ce) begin
      flags <= next_flags;
    end
  end

  // =====================================================
  // read data
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_ce) begin
      if (i_bus.rd && i_bus.addr == `RSC_OFS_FLAGS) begin
        o_rdata <= {2'h0, flags};
      end else begin
        o_rdata <= `RSC_SWRST_RST;
      end
    end
  end

  // =====================================================
  // outputs
  assign o_flags = flags;
  assign o_fuse_load = (state == ST_FUSE);
  assign o_scan_run = (state == ST_SCAN);
  assign o_sys_rst_n = (state == ST_RUN) && !req_any;
  assign o_dbg_rst_n = !(power_seq && state != ST_RUN);

  // =====================================================
  // checks
  AST_SWRST_READS_ZERO: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (i_ce && i_bus.rd && i_bus.addr == `RSC_OFS_SWRST) |=> (o_rdata == 8'h00)
  ) else $error("trigger register read not zero");

  AST_SW_GO_RESETS: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (i_ce && state == ST_RUN && sw_go) |-> !o_sys_rst_n ##1 (state == ST_HOLD)
  ) else $error("software trigger did not reset");

  AST_LOCKED_WRITE: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (i_ce && wr_swrst && !i_ccp_unlock && state == ST_RUN && !req_any) |=> (state == ST_RUN)
  ) else $error("locked write reached the trigger");

  AST_PIN_HOLDS: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (i_fuse.pin_en && !src_q.pin_n) |-> !o_sys_rst_n
  ) else $error("pin low but system running");

  AST_BOD_GATED: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (!i_fuse.bod_en && state == ST_RUN && !sw_go && !src_q.dbg && !src_q.por &&
     !(src_q.wdt && i_wdt_en) && !(i_fuse.pin_en && !src_q.pin_n)) |-> o_sys_rst_n
  ) else $error("disabled source caused reset");

  AST_POR_FLAGS: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (i_ce && src_q.por) |=> (flags == `RSC_FLAGS_POR_ONLY)
  ) else $error("power-on flags wrong");

  AST_BOOT_LOCK: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    boot_lock |-> (flags[`RSC_FLAGS_W-1:1] == '0)
  ) else $error("flag set before boot done");

  AST_FUSE_FIRST: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (i_ce && state == ST_HOLD && !req_any) |=> o_fuse_load
  ) else $error("fuse reload skipped");

  AST_NO_SUT_USER: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (i_ce && state == ST_FUSE && i_fuse_done && !power_seq && !i_fuse.scan_en && !req_any)
    |=> (state == ST_RUN)
  ) else $error("user reset got start-up delay");

  AST_SCAN_RUNS: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (i_ce && state == ST_FUSE && i_fuse_done && !sut_needed && i_fuse.scan_en && !req_any)
    |=> o_scan_run
  ) else $error("memory scan skipped");

  AST_W1C: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (i_ce && wr_flags && !req_any) |=>
    (flags == ($past(flags) & ~$past(i_bus.wdata[`RSC_FLAGS_W-1:0])))
  ) else $error("flag clear wrong");

  AST_DBG_USER: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (i_ce && state == ST_RUN && req_any && !pwr_req) |=> o_dbg_rst_n
  ) else $error("user reset hit debug port");

  AST_DBG_SUPPLY: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (i_ce && pwr_req) |=> !o_dbg_rst_n
  ) else $error("supply reset missed debug port");

  AST_REQ_RESTARTS: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (i_ce && req_any) |=> (state == ST_HOLD)
  ) else $error("request did not restart init");

  AST_WDT_RESETS: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (src_q.wdt && i_wdt_en) |-> !o_sys_rst_n
  ) else $error("watchdog request ignored");

  AST_SUT_POWER: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (i_ce && state == ST_FUSE && i_fuse_done && sut_needed && !req_any)
    |=> (state == ST_SUT)
  ) else $error("supply reset skipped start-up delay");

  AST_SUT_COUNT: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (i_ce && state == ST_SUT && sut_cnt != '0 && !req_any)
    |=> (state == ST_SUT && sut_cnt == $past(sut_cnt) - `RSC_CNT_W'(1))
  ) else $error("start-up delay cut short");

  AST_FLAGS_SET: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (i_ce && !boot_lock && !cause[`RSC_BIT_POR]) |=> ((flags & $past(cause)) == $past(cause))
  ) else $error("active cause flag not set");
endmodule : rsc_reset_source_controller

//--- verification/rsc_far_model.sv
// far side of the reset controller: pin driver, debugger request, fuse loader, scan unit
// assumes the bench commands pin and debugger requests on the controller clock
`timescale 1ns/1ps
module rsc_far_model #(
  parameter int P_LAT = 3
) (
  // clock
  input wire logic i_mclk,
  // bench commands
  input wire logic i_pin_low,
  input wire logic i_dbg_req,
  // handshakes
  input wire logic i_fuse_load,
  input wire logic i_scan_run,
  output logic o_fuse_done,
  output logic o_scan_done,
  // reset requests
  output logic o_pin_n,
  output logic o_dbg
);
  int fcnt;
  int scnt;
  // =====================================================
  // requests
  assign o_pin_n = ~i_pin_low;
  assign o_dbg = i_dbg_req;
  // =====================================================
  // handshake answers after a fixed latency
  always_ff @(posedge i_mclk) begin
    fcnt <= i_fuse_load ? fcnt + 1 : 0;
    scnt <= i_scan_run ? scnt + 1 : 0;
  end
  assign o_fuse_done = i_fuse_load && (fcnt >= P_LAT);
  assign o_scan_done = i_scan_run && (scnt >= P_LAT);
endmodule : rsc_far_model

//--- verification/tb_top.sv
// reset controller bench: register port tasks and reset source scenarios
// assumes rsc_pkg, rsc_consts.svh and rsc_far_model compiled first
`timescale 1ns/1ps
module tb_top;
  import rsc_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic change_protection = 1'b0;
  logic wdt_en = 1'b1;
  rsc_bus_s bus = '0;
  rsc_fuse_s fuse = '{pin_en: 1'b1, bod_en: 1'b1, scan_en: 1'b0, startup_time_setting: 3'h3};
  logic [4:0] req = '0;
  logic [7:0] rdata;
  logic [5:0] flags;
  logic fuse_load, fuse_done, scan_run, scan_done, sys_rst_n, dbg_rst_n, pin_n, dbg;
  logic saw_fuse = 1'b0;
  logic saw_scan = 1'b0;
  int num_errors = 0;
  int tests_run = 0;
  int c_wdt, c_bod, c_scan, cyc;
  always #12.5 i_mclk = ~i_mclk;
  always @(posedge i_mclk) begin
    if (fuse_load) saw_fuse = 1'b1;
    if (scan_run) saw_scan = 1'b1;
  end
  // =====================================================
  // instances
  rsc_reset_source_controller #(.P_SUT_STEP_CYC(4)) DUT (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(1'b1), .i_bus(bus), .o_rdata(rdata),
    .i_ccp_unlock(change_protection), .i_fuse(fuse), .i_wdt_en(wdt_en), .i_src({dbg, req[3], pin_n, req[1], req[0]}),
    .o_fuse_load(fuse_load), .i_fuse_done(fuse_done), .o_scan_run(scan_run), .i_scan_done(scan_done),
    .o_sys_rst_n(sys_rst_n), .o_dbg_rst_n(dbg_rst_n), .o_flags(flags));
  rsc_far_model far (
    .i_mclk(i_mclk), .i_pin_low(req[2]), .i_dbg_req(req[4]), .i_fuse_load(fuse_load),
    .i_scan_run(scan_run), .o_fuse_done(fuse_done), .o_scan_done(scan_done), .o_pin_n(pin_n), .o_dbg(dbg));
  // =====================================================
  // tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic see(input logic seen, input logic exp);
    chk(seen, exp);
    @(posedge i_mclk);
  endtask : see
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_mclk);
    bus <= '0;
    @(posedge i_mclk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_mclk);
    bus <= '0;
    #1 chk(rdata, exp);
    @(posedge i_mclk);
  endtask : rd
  task automatic wait_run(output int n);
    n = 0;
    #1;
    while (sys_rst_n !== 1'b1 && n < 400) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    if (n >= 400) begin
      num_errors++;
      $display("[ERR] %0t reset never released", $time);
    end
    @(posedge i_mclk);
  endtask : wait_run
  task automatic hit(input int b, input logic en, input logic [5:0] exp, input logic dbg_exp, output int n);
    wr(8'h00, 8'h3f);
    req[b] <= 1'b1;
    repeat (6) @(posedge i_mclk);
    #1 chk(sys_rst_n, !en);
    see(dbg_rst_n, dbg_exp);
    req[b] <= 1'b0;
    wait_run(n);
    rd(8'h00, {2'b00, exp});
    chk(flags, exp);
  endtask : hit
  task automatic finish_test;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test
  // =====================================================
  // scenarios
  initial begin
    repeat (4) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    req[3] <= 1'b1;
    repeat (6) @(posedge i_mclk);
    req[3] <= 1'b0;
    wait_run(cyc);
    rd(8'h00, 8'h01);
    rd(8'h01, 8'h00);
    rd(8'h07, 8'h00);
    wr(8'h00, 8'h00);
    rd(8'h00, 8'h01);
    wr(8'h00, 8'h01);
    rd(8'h00, 8'h00);
    wr(8'h01, 8'h01);
    #1 see(sys_rst_n, 1'b1);
    rd(8'h00, 8'h00);
    change_protection <= 1'b1;
    saw_fuse = 1'b0;
    wr(8'h01, 8'h01);
    change_protection <= 1'b0;
    #1 see(sys_rst_n, 1'b0);
    wait_run(cyc);
    chk(saw_fuse, 1'b1);
    chk(dbg_rst_n, 1'b1);
    rd(8'h00, 8'h10);
    hit(2, 1'b1, 6'h04, 1'b1, cyc);
    fuse.pin_en <= 1'b0;
    hit(2, 1'b0, 6'h00, 1'b1, cyc);
    wdt_en <= 1'b0;
    hit(3, 1'b0, 6'h00, 1'b1, cyc);
    wdt_en <= 1'b1;
    hit(3, 1'b1, 6'h08, 1'b1, c_wdt);
    hit(4, 1'b1, 6'h20, 1'b1, cyc);
    hit(1, 1'b1, 6'h02, 1'b0, c_bod);
    chk(c_bod - c_wdt, 3 * 4);
    fuse.bod_en <= 1'b0;
    hit(1, 1'b0, 6'h00, 1'b1, cyc);
    fuse.scan_en <= 1'b1;
    saw_scan = 1'b0;
    hit(3, 1'b1, 6'h08, 1'b1, c_scan);
    chk(saw_scan, 1'b1);
    chk(c_scan > c_wdt, 1'b1);
    hit(0, 1'b1, 6'h01, 1'b0, cyc);
    finish_test();
  end
  initial begin
    #(25 * 8000);
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    finish_test();
  end
endmodule : tb_top
